//--- design/case_output_defs.vh
// Constants for the monitoring case output control block
`ifndef CASE_OUTPUT_DEFS_VH
`define CASE_OUTPUT_DEFS_VH

// ==========================================================
// Clock and timing
`define CLK_PERIOD_NS     25
`define MS_PERIOD_NS      1000000
`define MS_CYCLES         (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define SWITCH_BASE_MS    10
`define SWITCH_STEP_MS    40
`define MS_PER_SEC        1000
`define RESTART_MAX_SEC   60

// ==========================================================
// Register byte addresses
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_CASE_BASE     8'h40
`define CASE_COUNT        16

// ==========================================================
// Control register fields
`define CTRL_DAZZLE_BIT   0
`define CTRL_ROTATE_BIT   1
`define CTRL_BUSIN_BIT    2
`define CTRL_STEPS_LSB    8
`define CTRL_RESTART_LSB  16
`define CTRL_STATION_LSB  24
`define CTRL_RESET        32'h00000000

// ==========================================================
// Case entry fields
`define CASE_F1_LSB       0
`define CASE_F2_LSB       4
`define CASE_AL1_BIT      8
`define CASE_AL2_BIT      9
`define CASE_MULTI_LSB    12
`define CASE_RESET        16'h1000

// ==========================================================
// Field bus messages
`define EMCY_GENERIC      16'h1000

`endif

//--- design/input_sync.v
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module input_sync #(
  parameter WIDTH = 5
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             nrst,
  // Pin side
  input  wire [WIDTH-1:0] pin_in,
  // Filtered level
  output wire [WIDTH-1:0] level_out
);

  // ==========================================================
  // One chain per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1;    // Metastable stage, read only by s2
      reg s2;    // Second stage
      reg s3;    // Third stage
      reg level; // Accepted level
      // Chain and accept once stages two and three agree
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          s1    <= 1'b0;
          s2    <= 1'b0;
          s3    <= 1'b0;
          level <= 1'b0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level <= s3;
          end
        end
      end
      assign level_out[i] = level;
    end
  endgenerate

endmodule

//--- design/output_channel.v
// One switching output: multiple sampling, restart delay, overrides
`timescale 1ns/10ps
module output_channel (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // Timing
  input  wire        scan_tick,
  input  wire        ms_tick,
  // Field evaluation
  input  wire        obj,
  input  wire [3:0]  multi,
  input  wire [15:0] restart_ms,
  // Overrides
  input  wire        always_on,
  input  wire        standby,
  input  wire        dazzle,
  input  wire        dazzle_supp,
  // Output
  output reg         out_on
);

  reg [3:0]  hits;        // Consecutive scans with object
  reg [15:0] clear_ms;    // Time field has stayed clear
  reg        field_clear; // Last scan saw no object

  // ==========================================================
  // Output state
  // Priority: stand-by, always active, dazzle, normal evaluation
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_on      <= 1'b0;
      hits        <= 4'h0;
      clear_ms    <= 16'h0000;
      field_clear <= 1'b0;
    end else if (standby) begin
      out_on   <= 1'b0;
      hits     <= 4'h0;
      clear_ms <= 16'h0000;
    end else if (always_on) begin
      out_on   <= 1'b1;
      hits     <= 4'h0;
      clear_ms <= 16'h0000;
    end else if (dazzle && !dazzle_supp) begin
      out_on   <= 1'b0;
      clear_ms <= 16'h0000;
    end else if (dazzle) begin
      out_on <= 1'b1;
    end else begin
      if (scan_tick) begin
        field_clear <= !obj;
        if (obj) begin
          clear_ms <= 16'h0000;
          // Count n-1 stored, so off on the n-th hit
          if (hits == multi) begin
            out_on <= 1'b0;
          end else begin
            hits <= hits + 4'h1;
          end
        end else begin
          hits <= 4'h0;
        end
      end else if (!out_on && field_clear) begin
        // Clear field must persist for the full restart time
        if (clear_ms >= restart_ms) begin
          out_on   <= 1'b1;
          clear_ms <= 16'h0000;
        end else if (ms_tick) begin
          clear_ms <= clear_ms + 16'h0001;
        end
      end
    end
  end

endmodule

//--- design/monitoring_case_output_control.v
// Monitoring case selection and switching output control, top level
//
// Functional notes
// - Dazzle suppression off after reset
// - Unsuppressed dazzle may switch outputs off
// - Suppressed dazzle keeps outputs on
// - Sixteen cases, each with two fields
// - Always-active output stays on in case
// - Stand-by also turns always-active outputs off
// - Stand-by turns outputs and laser off
// - Dedicated stand-by input, sampled by device
// - Four inputs binary, first most significant
// - Switch-on delay adjustable in 40 ms steps
// - Bus inputs evaluated only when enabled
// - Bus cyclically reports outputs, inputs, status
// - Emergency uses generic code, details after
// - Process data uses all eight bytes
// - Output on when field clear, else off
// - Rotated display extinguishes decimal point
// - Restart after clear for 0-60 s
// - Off after 1-16 consecutive hits, default 2
`timescale 1ns/10ps
`include "case_output_defs.vh"
module monitoring_case_output_control #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Static control pins
  input  wire [3:0]  case_pins,
  input  wire        low_power_request_input,
  // Scan engine results
  input  wire        scan_tick,
  input  wire [15:0] field_detect,
  input  wire        dazzle_detect,
  input  wire        contamination,
  input  wire        device_error,
  input  wire [7:0]  error_detail,
  // Field bus receive process data
  input  wire [63:0] pdo_rx_data,
  input  wire        pdo_rx_valid,
  // Field bus transmit process data
  output reg  [63:0] pdo_tx_data,
  output reg         pdo_tx_valid,
  // Field bus emergency
  output reg  [15:0] emcy_code,
  output reg  [39:0] emcy_mfr,
  output reg         emcy_valid,
  output reg  [6:0]  bus_station_number,
  // Switching outputs and indicators
  output wire        field_output_one,
  output wire        field_output_two,
  output reg         laser_enable,
  output reg         decimal_point
);

  // ==========================================================
  // Configuration state
  reg  [31:0] ctrl;                 // Control word
  wire        dazzle_supp;          // Dazzle suppression enable
  wire        display_rot;          // Display turned by 180 degrees
  wire        bus_in_en;            // Accept inputs from field bus
  wire [3:0]  switch_steps;         // Switch-on delay steps
  wire [5:0]  restart_sec;          // Restart delay in seconds
  wire [15:0] restart_ms;           // Restart delay in ms
  wire [15:0] case_tab [0:15];      // Case table read view

  assign dazzle_supp  = ctrl[`CTRL_DAZZLE_BIT];
  assign display_rot  = ctrl[`CTRL_ROTATE_BIT];
  assign bus_in_en    = ctrl[`CTRL_BUSIN_BIT];
  assign switch_steps = ctrl[`CTRL_STEPS_LSB+3:`CTRL_STEPS_LSB];
  // Values above the top figure are clipped to it
  assign restart_sec  = (ctrl[`CTRL_RESTART_LSB+5:`CTRL_RESTART_LSB] > `RESTART_MAX_SEC) ?
                        6'd`RESTART_MAX_SEC : ctrl[`CTRL_RESTART_LSB+5:`CTRL_RESTART_LSB];
  assign restart_ms   = restart_sec * 16'd`MS_PER_SEC;

  // ==========================================================
  // Millisecond enable
  reg  [15:0] ms_cnt;               // Divider count
  reg         ms_tick;              // One-cycle pulse per ms

  // Free-running divider feeding every slow timer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_CYCLES - 1) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Pin inputs
  wire [4:0]  pin_level;            // Filtered pins, standby on top

  input_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .pin_in    ({low_power_request_input, case_pins}),
    .level_out (pin_level)
  );

  // ==========================================================
  // Field bus input values
  reg  [3:0]  rx_case;              // Case inputs from bus
  reg         rx_standby;           // Stand-by request from bus

  // Latch received inputs only while the option is enabled
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_case    <= 4'h0;
      rx_standby <= 1'b0;
    end else if (pdo_rx_valid && bus_in_en) begin
      rx_case    <= pdo_rx_data[3:0];
      rx_standby <= pdo_rx_data[4];
    end
  end

  wire [3:0]  src_case;             // Selected case input source
  wire        standby;              // Effective stand-by
  // Disabling the option falls back to the pins at once
  assign src_case = bus_in_en ? rx_case : pin_level[3:0];
  assign standby  = bus_in_en ? rx_standby : pin_level[4];

  // ==========================================================
  // Case switchover with switch-on delay
  reg  [3:0]  pend_case;            // Candidate input code
  reg  [9:0]  stable_ms;            // Time candidate has held
  reg  [3:0]  act_case;             // Active code, case = code + 1
  wire [9:0]  delay_ms;             // Required stable time
  reg         case_load;            // Load field assignments

  // Base covers a clean electronic driver; steps cover bounce
  assign delay_ms = 10'd`SWITCH_BASE_MS + switch_steps * 10'd`SWITCH_STEP_MS;

  // Restart stability timer on every input change
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_case <= 4'h0;
      stable_ms <= 10'h000;
      act_case  <= 4'h0;
      case_load <= 1'b1;
    end else begin
      case_load <= 1'b0;
      if (src_case != pend_case) begin
        pend_case <= src_case;
        stable_ms <= 10'h000;
      end else if (pend_case != act_case) begin
        if (stable_ms >= delay_ms) begin
          act_case  <= pend_case;
          case_load <= 1'b1;
        end else if (ms_tick) begin
          stable_ms <= stable_ms + 10'h001;
        end
      end else begin
        stable_ms <= 10'h000;
      end
    end
  end

  // ==========================================================
  // Active field assignment, loaded as one unit
  reg  [3:0]  act_f1;               // Field for output one
  reg  [3:0]  act_f2;               // Field for output two
  reg         act_al1;              // Output one always active
  reg         act_al2;              // Output two always active
  reg  [3:0]  act_multi;            // Multiple sampling minus one
  wire [15:0] entry;                // Entry of the active case

  assign entry = case_tab[act_case];

  // Loaded after reset and at each switchover; entry rewrites wait for the next one
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      act_f1    <= 4'h0;
      act_f2    <= 4'h0;
      act_al1   <= 1'b0;
      act_al2   <= 1'b0;
      act_multi <= 4'h1;
    end else if (case_load) begin
      act_f1    <= entry[`CASE_F1_LSB+3:`CASE_F1_LSB];
      act_f2    <= entry[`CASE_F2_LSB+3:`CASE_F2_LSB];
      act_al1   <= entry[`CASE_AL1_BIT];
      act_al2   <= entry[`CASE_AL2_BIT];
      act_multi <= entry[`CASE_MULTI_LSB+3:`CASE_MULTI_LSB];
    end
  end

  // ==========================================================
  // Switching outputs
  output_channel u_out1 (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .scan_tick   (scan_tick),
    .ms_tick     (ms_tick),
    .obj         (field_detect[act_f1]),
    .multi       (act_multi),
    .restart_ms  (restart_ms),
    .always_on   (act_al1),
    .standby     (standby),
    .dazzle      (dazzle_detect),
    .dazzle_supp (dazzle_supp),
    .out_on      (field_output_one)
  );

  output_channel u_out2 (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .scan_tick   (scan_tick),
    .ms_tick     (ms_tick),
    .obj         (field_detect[act_f2]),
    .multi       (act_multi),
    .restart_ms  (restart_ms),
    .always_on   (act_al2),
    .standby     (standby),
    .dazzle      (dazzle_detect),
    .dazzle_supp (dazzle_supp),
    .out_on      (field_output_two)
  );

  // ==========================================================
  // Laser, display point and station number
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      laser_enable       <= 1'b0;
      decimal_point      <= 1'b1;
      bus_station_number <= 7'h00;
    end else begin
      laser_enable       <= !standby;
      decimal_point      <= !display_rot;
      bus_station_number <= ctrl[`CTRL_STATION_LSB+6:`CTRL_STATION_LSB];
    end
  end

  // ==========================================================
  // Cyclic process data, one frame per scan
  reg  [15:0] scan_count;           // Running scan number

  // All eight bytes carry data; last two count scans
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pdo_tx_data  <= 64'h0;
      pdo_tx_valid <= 1'b0;
      scan_count   <= 16'h0000;
    end else begin
      pdo_tx_valid <= scan_tick;
      if (scan_tick) begin
        scan_count  <= scan_count + 16'h0001;
        pdo_tx_data <= {scan_count,
                        pend_case, act_case,
                        restart_sec, standby, dazzle_detect,
                        2'h0, dazzle_supp, bus_in_en, device_error,
                        laser_enable, contamination, dazzle_detect,
                        act_f2, act_f1,
                        3'h0, pin_level[4], pin_level[3:0],
                        3'h0, device_error | contamination,
                        !field_output_two, !field_output_one,
                        field_output_two, field_output_one};
      end
    end
  end

  // ==========================================================
  // Emergency message on a new error
  reg         err_seen;             // Previous error level

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_seen   <= 1'b0;
      emcy_valid <= 1'b0;
      emcy_code  <= 16'h0000;
      emcy_mfr   <= 40'h0;
    end else begin
      err_seen   <= device_error;
      emcy_valid <= device_error && !err_seen;
      if (device_error && !err_seen) begin
        emcy_code <= `EMCY_GENERIC;
        emcy_mfr  <= {16'h0000, error_detail, 8'h00};
      end
    end
  end

  // ==========================================================
  // Case table storage, one word per entry
  genvar k;
  generate
    for (k = 0; k < `CASE_COUNT; k = k + 1) begin : g_case
      reg [15:0] word; // Entry value
      // Default entry: fields 0, none always on, sampling two
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          word <= `CASE_RESET;
        end else if (reg_wr && (reg_addr == `REG_CASE_BASE + 4 * k)) begin
          word <= reg_wdata[15:0];
        end
      end
      assign case_tab[k] = word;
    end
  endgenerate

  // ==========================================================
  // Register write and read
  wire        case_hit;             // Address falls in case table
  wire [3:0]  case_idx;             // Table index from address
  assign case_hit = (reg_addr[7:6] == 2'b01) && (reg_addr[1:0] == 2'b00);
  assign case_idx = reg_addr[5:2];

  // Read data is valid only in the cycle after the strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl      <= `CTRL_RESET;
      reg_rdata <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `REG_CTRL) begin
        ctrl <= reg_wdata;
      end
      if (reg_rd) begin
        if (reg_addr == `REG_CTRL) begin
          reg_rdata <= ctrl;
        end else if (reg_addr == `REG_STATUS) begin
          reg_rdata <= {16'h0, pend_case, act_case,
                        2'h0, laser_enable, standby,
                        contamination, device_error,
                        field_output_two, field_output_one};
        end else if (case_hit) begin
          reg_rdata <= {16'h0, case_tab[case_idx]};
        end else begin
          reg_rdata <= 32'h0; // Unmapped reads as zero
        end
      end else begin
        reg_rdata <= 32'h0;
      end
    end
  end

endmodule

//--- verification/case_controller_model.sv
// Vehicle controller model driving the static case and stand-by inputs
`timescale 1ns/10ps
module case_controller_model (
  // Clock
  input  wire       clk_sys,
  // Requests from the bench
  input  wire [3:0] want_code,
  input  wire       want_low_power_request_input,
  input  wire       slow,
  // Static inputs of the device
  output reg  [3:0] case_pins,
  output reg        low_power_request_input
);
  reg [6:0] lag;  // Cycles spent on a slow switchover

  initial begin
    case_pins = 4'h0;
    low_power_request_input = 1'b0;
    lag = 7'h0;
  end

  // ===========
  // Switchover, prompt or in two steps
  // Slow mode moves the lower pair first, so the device sees a false code
  always @(posedge clk_sys) begin
    low_power_request_input <= want_low_power_request_input;
    if (case_pins == want_code) begin
      lag <= 7'h0;
    end else if (!slow || lag == 7'h32) begin
      case_pins <= want_code;
    end else begin
      // Whole change lands within 5 ms at ten cycles a millisecond
      lag <= lag + 7'h1;
      case_pins[1:0] <= want_code[1:0];
    end
  end
endmodule

//--- verification/monitoring_case_output_control_sva.sv
// Concurrent checks on the case selection and switching output ports
`timescale 1ns/10ps
module monitoring_case_output_control_sva (
  // Clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // Register writes
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  // Scan engine and pins
  input wire        scan_tick,
  input wire        dazzle_detect,
  input wire        device_error,
  input wire        low_power_request_input,
  // Field bus outputs
  input wire [63:0] pdo_tx_data,
  input wire        pdo_tx_valid,
  input wire [15:0] emcy_code,
  input wire        emcy_valid,
  // Switching outputs and indicators
  input wire        field_output_one,
  input wire        field_output_two,
  input wire        laser_enable,
  input wire        decimal_point
);
  reg [31:0] ctrl;  // Shadow of the control word

  // ===========
  // Shadow copy, so overrides are known without peeking inside
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 32'h0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      ctrl <= reg_wdata;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ===========
  // Assertions
  AST_PDO_AFTER_SCAN: assert property (scan_tick |=> pdo_tx_valid)
    else $error("No frame after a scan");
  AST_PDO_ONLY: assert property (pdo_tx_valid |-> $past(scan_tick))
    else $error("Frame without a scan");
  AST_PDO_INVERSE: assert property (pdo_tx_valid |-> pdo_tx_data[3:2] == ~pdo_tx_data[1:0])
    else $error("Inverted output bits wrong");
  AST_EMCY_RISE: assert property ($rose(device_error) |=> emcy_valid && emcy_code == 16'h1000)
    else $error("Emergency missing or wrong code");
  AST_EMCY_ONLY: assert property (emcy_valid |-> $past(device_error) && !$past(device_error, 2))
    else $error("Emergency without a new fault");
  // Eight samples cover the pin synchroniser and the output register
  AST_LOW_POWER_REQUEST_INPUT_OFF: assert property ((!ctrl[2] && low_power_request_input)[*8] |-> !field_output_one && !field_output_two && !laser_enable)
    else $error("Stand-by left something on");
  AST_LASER_ON: assert property ((!ctrl[2] && !low_power_request_input)[*8] |-> laser_enable)
    else $error("Laser off outside stand-by");
  AST_DAZZLE_SUPP: assert property ((ctrl[0] && !ctrl[2] && dazzle_detect && !low_power_request_input)[*8] |-> field_output_one && field_output_two)
    else $error("Suppressed dazzle dropped an output");
  AST_DP_ROTATE: assert property ($stable(ctrl[1]) |-> decimal_point == !ctrl[1])
    else $error("Decimal point disagrees with rotation");

  // Main scenarios reached
  cover property ($fell(field_output_one));
  cover property (emcy_valid);
  cover property ($fell(laser_enable));
endmodule

bind monitoring_case_output_control monitoring_case_output_control_sva monitoring_case_output_control_sva_i (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .scan_tick(scan_tick), .dazzle_detect(dazzle_detect), .device_error(device_error),
  .low_power_request_input(low_power_request_input), .pdo_tx_data(pdo_tx_data),
  .pdo_tx_valid(pdo_tx_valid), .emcy_code(emcy_code), .emcy_valid(emcy_valid),
  .field_output_one(field_output_one), .field_output_two(field_output_two),
  .laser_enable(laser_enable), .decimal_point(decimal_point));

//--- verification/test_monitoring_case_output_control.sv
// Self-checking bench for the case selection and switching output block
`timescale 1ns/10ps
module test_monitoring_case_output_control;
  // ===========
  // Stimulus and observed signals
  reg         clk_sys, nrst, reg_wr, reg_rd, scan_tick;
  reg         dazzle_detect, contamination, device_error, pdo_rx_valid;
  reg  [7:0]  reg_addr, error_detail;
  reg  [31:0] reg_wdata, d;
  reg  [15:0] field_detect;
  reg  [63:0] pdo_rx_data;
  reg  [3:0]  want_code;   // Case code asked of the controller
  reg         want_low_power_request_input;   // Stand-by asked of the controller
  reg         slow;        // Controller settles in two steps
  integer     errors, n_compared, cycles;
  wire [3:0]  case_pins;
  wire        low_power_request_input, pdo_tx_valid, emcy_valid;
  wire        field_output_one, field_output_two, laser_enable, decimal_point;
  wire [31:0] reg_rdata;
  wire [63:0] pdo_tx_data;
  wire [15:0] emcy_code;
  wire [39:0] emcy_mfr;
  wire [6:0]  bus_station_number;

  // Ten cycles a millisecond keeps the timers short
  monitoring_case_output_control #(.MS_CYCLES(10)) monitoring_case_output_control_i (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .case_pins(case_pins),
    .low_power_request_input(low_power_request_input), .scan_tick(scan_tick),
    .field_detect(field_detect), .dazzle_detect(dazzle_detect),
    .contamination(contamination), .device_error(device_error), .error_detail(error_detail),
    .pdo_rx_data(pdo_rx_data), .pdo_rx_valid(pdo_rx_valid), .pdo_tx_data(pdo_tx_data),
    .pdo_tx_valid(pdo_tx_valid), .emcy_code(emcy_code), .emcy_mfr(emcy_mfr),
    .emcy_valid(emcy_valid), .bus_station_number(bus_station_number),
    .field_output_one(field_output_one), .field_output_two(field_output_two),
    .laser_enable(laser_enable), .decimal_point(decimal_point));

  case_controller_model case_controller_model_i (
    .clk_sys(clk_sys), .want_code(want_code), .want_low_power_request_input(want_low_power_request_input), .slow(slow),
    .case_pins(case_pins), .low_power_request_input(low_power_request_input));

  always #12.5 clk_sys = ~clk_sys;

  // Hang guard, far above the dozen thousand cycles needed
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      close_out;
    end
  end

  // ===========
  // Shared tasks
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task scan(input [15:0] f);
    begin
      @(posedge clk_sys);
      field_detect <= f;
      scan_tick <= 1'b1;
      @(posedge clk_sys);
      scan_tick <= 1'b0;
    end
  endtask
  task bus_in(input [63:0] v);
    begin
      @(posedge clk_sys);
      pdo_rx_data <= v;
      pdo_rx_valid <= 1'b1;
      @(posedge clk_sys);
      pdo_rx_valid <= 1'b0;
    end
  endtask
  task wait_cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask

  // ===========
  // Scenarios
  task t_reset;
    begin
      rd(8'h00); check(d, 32'h0);
      rd(8'h40); check(d, 32'h1000);
      rd(8'h3c); check(d, 32'h0);
      check(decimal_point, 1'b1);
    end
  endtask
  task t_sampling;
    begin
      scan(16'h0); wait_cyc(4); check({field_output_two, field_output_one}, 2'h3);
      scan(16'h1); scan(16'h0); scan(16'h1); wait_cyc(2); check(field_output_one, 1'b1);
      scan(16'h1); wait_cyc(2); check({field_output_two, field_output_one}, 2'h0);
      wr(8'h00, 32'h0001_0000); scan(16'h0);
      wait_cyc(5000); check(field_output_one, 1'b0);
      wait_cyc(5200); check(field_output_one, 1'b1);
    end
  endtask
  task t_select;
    begin
      wr(8'h60, 32'h0053);
      wr(8'h00, 32'h0100);
      want_code <= 4'h8;
      wait_cyc(300); rd(8'h04); check(d[15:8], 8'h80);
      wait_cyc(300); rd(8'h04); check(d[11:8], 4'h8);
      scan(16'h0008); wait_cyc(2); check({field_output_two, field_output_one}, 2'h2);
      scan(16'h0); wait_cyc(4);
    end
  endtask
  task t_always;
    begin
      wr(8'h54, 32'h0100);
      wr(8'h00, 32'h0);
      slow <= 1'b1;
      want_code <= 4'h5;
      wait_cyc(250); rd(8'h04); check(d[11:8], 4'h5);
      scan(16'h1); wait_cyc(2); check({field_output_two, field_output_one}, 2'h1);
      @(posedge clk_sys) want_low_power_request_input <= 1'b1;
      wait_cyc(12); check({laser_enable, field_output_two, field_output_one}, 3'h0);
      @(posedge clk_sys) want_low_power_request_input <= 1'b0;
      wait_cyc(12); check(laser_enable, 1'b1);
    end
  endtask
  task t_dazzle;
    begin
      scan(16'h0); wait_cyc(4);
      @(posedge clk_sys) dazzle_detect <= 1'b1;
      wait_cyc(4); check({field_output_two, field_output_one}, 2'h1);
      wr(8'h00, 32'h1); scan(16'h1);
      wait_cyc(8); check({field_output_two, field_output_one}, 2'h3);
      @(posedge clk_sys) dazzle_detect <= 1'b0;
      wr(8'h00, 32'h0);
    end
  endtask
  task t_bus;
    begin
      bus_in(64'h12); wait_cyc(150); rd(8'h04);
      check({laser_enable, d[11:8]}, 5'h15);
      wr(8'h00, 32'h4); bus_in(64'h12); wait_cyc(150); rd(8'h04);
      check({laser_enable, d[11:8]}, 5'h02);
      bus_in(64'h02); wr(8'h00, 32'h0);
    end
  endtask
  task t_report;
    begin
      @(posedge clk_sys) contamination <= 1'b1;
      scan(16'h0); #1 check(pdo_tx_valid, 1'b1);
      check({pdo_tx_data[25], pdo_tx_data[4], pdo_tx_data[12:8]}, 7'h65);
      @(posedge clk_sys) contamination <= 1'b0;
      error_detail <= 8'h5a;
      device_error <= 1'b1;
      wait_cyc(1); check({emcy_valid, emcy_code, emcy_mfr}, {1'b1, 16'h1000, 40'h5a00});
      @(posedge clk_sys) device_error <= 1'b0;
      wr(8'h00, 32'h0700_0002); wait_cyc(3);
      check({bus_station_number, decimal_point}, 8'h0e);
    end
  endtask

  // ===========
  // Verdict and end of run
  task close_out;
    begin
      if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial begin
    clk_sys = 1'b0; nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; scan_tick = 1'b0;
    dazzle_detect = 1'b0; contamination = 1'b0; device_error = 1'b0; pdo_rx_valid = 1'b0;
    reg_addr = 8'h0; error_detail = 8'h0; reg_wdata = 32'h0; field_detect = 16'h0;
    pdo_rx_data = 64'h0; want_code = 4'h0; want_low_power_request_input = 1'b0; slow = 1'b0;
    d = 32'h0; errors = 0; n_compared = 0; cycles = 0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset; t_sampling; t_select; t_always; t_dazzle; t_bus; t_report;
    close_out;
  end
endmodule
